// [fault_sup_pkg.sv]
package fault_sup_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ          = 100_000_000;  // System clock rate
    localparam int unsigned TICK_MS         = 1;            // Base tick period in ms
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS; // Cycles per tick
    localparam int unsigned REMOTE_TO_MS    = 60_000;       // Remote not-ready limit, one minute
    localparam int unsigned FAN_LOW_MS      = 5_000;        // Fan slow limit, 5 s
    localparam int unsigned FAN_MIN_RPS     = 2;            // Least fan speed, rev/s
    localparam int unsigned FAN_WIN_MS      = 1000;         // Speed gate window, ms
    localparam int unsigned COVER_OFF_MS    = 30_000;       // Restart pump-off limit, 30 s
    localparam int unsigned MS_W            = 17;           // Width of ms counters

    // Error flag positions
    localparam int unsigned E_TIMEOUT       = 0;
    localparam int unsigned E_SHUTDOWN      = 1;
    localparam int unsigned E_REMOTE_TO     = 2;
    localparam int unsigned E_SYNC_LOST     = 3;
    localparam int unsigned E_LEAK          = 4;
    localparam int unsigned E_LEAK_OPEN     = 5;
    localparam int unsigned E_LEAK_SHORT    = 6;
    localparam int unsigned E_COMP_OPEN     = 7;
    localparam int unsigned E_COMP_SHORT    = 8;
    localparam int unsigned E_FAN_FAIL      = 9;
    localparam int unsigned E_OPEN_COVER    = 10;
    localparam int unsigned E_RESTART_COVER = 11;
    localparam int unsigned E_SOLVENT_ZERO  = 12;
    localparam int unsigned E_PRESS_HIGH    = 13;
    localparam int unsigned NUM_ERR         = 14;

    localparam logic [NUM_ERR-1:0] ERR_RST  = 14'h0000;     // Flags after reset

    // Sensor comparison inputs, sampled on the system clock
    typedef struct packed {
        logic leak_detect;   // Leak algorithm verdict
        logic leak_cur_low;  // Leak sensor current below lower limit
        logic leak_cur_high; // Leak sensor current above upper limit
        logic comp_res_high; // Compensation resistance above upper limit
        logic comp_res_low;  // Compensation resistance below lower limit
        logic press_high;    // Pressure above upper limit
    } sensor_cmp_t;

    // Run phase of the instrument
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_RUN  = 2'b01,
        PH_POST = 2'b11
    } phase_t;

    // Event log record
    typedef struct packed {
        logic                  valid; // One-cycle write strobe
        logic [3:0]            code;  // Index of the error that fired
    } log_entry_t;

endpackage

// [ms_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// Counts enabled ticks while active; expires at a given limit
module ms_timer #(
    parameter int unsigned W = 17  // Counter width
) (
    input  wire logic         clk_sys, // System clock
    input  wire logic         rst,     // Synchronous reset
    input  wire logic         tick,    // Count enable pulse
    input  wire logic         active,  // Count while high, clear when low
    input  wire logic [W-1:0] limit,   // Expiry count
    output logic              expired  // Level, count reached limit
);
    logic [W-1:0] cnt_ff;  // Tick count
    logic [W-1:0] nxt_cnt; // Next count

    // Hold at limit, clear when inactive
    always_comb begin
        nxt_cnt = cnt_ff;
        if (!active) begin
            nxt_cnt = '0;
        end else if (tick && cnt_ff < limit) begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    // Register count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign expired = active && (cnt_ff >= limit);
endmodule
`default_nettype wire

// [fault_supervisor.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// - Any error lights red lamp; each cycle logs the lowest newly set error only
// - Any error aborts running analysis
// - Not-ready too long in sequence: timeout
// - Post-run timeout switches pump off, reports
// - Remote shutdown line low raises error
// - Remote not-ready after one minute: error
// - Module missing during analysis: sync lost
// - Leak verdict from leak plus compensation
// - Leak current below limit: sensor open
// - Leak current above limit: sensor short
// - Compensation resistance high: sensor open
// - Compensation resistance low: sensor short
// - Fan under 2 rps over 5 s fails
// - Cover removed: fan off, error
// - Restart without cover: pump off after 30 s, held off until reset
// - Solvent volume below setting: error, resettable
// - Pressure above upper limit raises error
module fault_supervisor
    import fault_sup_pkg::*;
#(
    parameter int unsigned REMOTE_TO_TICKS = REMOTE_TO_MS, // Remote limit in ms ticks
    parameter int unsigned FAN_LOW_TICKS   = FAN_LOW_MS,   // Fan slow limit in ms ticks
    parameter int unsigned FAN_WIN_TICKS   = FAN_WIN_MS,   // Fan gate window in ms ticks
    parameter int unsigned COVER_TICKS     = COVER_OFF_MS, // Restart pump-off delay
    parameter int unsigned TICK_DIV        = TICK_CYCLES,  // Clock cycles per tick
    parameter int unsigned VOL_W           = 24            // Solvent volume width
) (
    input  wire logic                        clk_sys,         // System clock
    input  wire logic                        rst,             // Sync reset, restart
    input  wire fault_sup_pkg::sensor_cmp_t  sensor_cmp,      // Sensor comparator levels
    input  wire logic                        remote_shdn_n,   // Remote shutdown pin, low active
    input  wire logic                        remote_nrdy_n,   // Remote not-ready pin, low active
    input  wire logic                        fan_hall,        // Fan hall pulse pin
    input  wire logic                        cover_present,   // Foam sensor pin, high in place
    input  wire logic [15:0]                 mod_config,      // Configured modules
    input  wire logic [15:0]                 mod_present,     // Modules seen on system bus
    input  wire logic                        analysis_start,  // Analysis start pulse
    input  wire logic                        analysis_done,   // Analysis completed pulse
    input  wire logic                        seq_run,         // Sequence run in progress
    input  wire logic                        not_ready,       // Local not-ready level
    input  wire logic                        timeout_en,      // Post-run pump-off requested
    input  wire logic [MS_W-1:0]             timeout_ticks,   // Programmed timeout, ms
    input  wire logic                        solvent_en,      // Volume feature enabled
    input  wire logic [VOL_W-1:0]            solvent_fill,    // Volume loaded on refill
    input  wire logic [VOL_W-1:0]            solvent_limit,   // Volume error threshold
    input  wire logic                        solvent_reset,   // Refill, reload counter
    input  wire logic                        solvent_dec,     // Volume drawn pulse
    input  wire logic [7:0]                  solvent_step,    // Volume per pulse
    input  wire logic [NUM_ERR-1:0]          err_clear,       // Per-flag clear pulse
    output logic [NUM_ERR-1:0]               err_flags,       // Latched error flags
    output logic                             lamp_red,        // Red status lamp
    output logic                             analysis_abort,  // Abort pulse
    output logic                             running,         // Analysis in progress
    output logic                             pump_en,         // Pump drive enable
    output logic                             fan_en,          // Fan drive enable
    output fault_sup_pkg::log_entry_t        log_entry        // Event log write
);
    // Three-stage samplers for pins, packed {cover, hall, nrdy, shdn}
    logic [3:0] sa_ff, sb_ff, sc_ff, pin_q_ff;               // Sync stages, accepted levels
    logic       shdn_q_ff, nrdy_q_ff, hall_q_ff, cover_q_ff; // Accepted level per pin
    logic       hall_q_d_ff;                                 // Hall edge delay

    assign {cover_q_ff, hall_q_ff, nrdy_q_ff, shdn_q_ff} = pin_q_ff;

    // Sample pins; a change counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sa_ff       <= 4'hB; // Idle: cover, nrdy, shdn high
            sb_ff       <= 4'hB;
            sc_ff       <= 4'hB;
            pin_q_ff    <= 4'hB;
            hall_q_d_ff <= 1'b0;
        end else begin
            sa_ff       <= {cover_present, fan_hall, remote_nrdy_n, remote_shdn_n};
            sb_ff       <= sa_ff;
            sc_ff       <= sb_ff;
            pin_q_ff    <= (sb_ff & sc_ff) | (pin_q_ff & (sb_ff ^ sc_ff));
            hall_q_d_ff <= hall_q_ff;
        end
    end

    // Millisecond tick divider
    logic [31:0] div_ff;  // Divider count
    logic [31:0] nxt_div; // Next divider count
    logic        tick;    // One-cycle ms enable

    // Wrap divider each tick
    always_comb begin
        tick    = (div_ff == TICK_DIV - 1);
        nxt_div = tick ? '0 : div_ff + 32'h1;
    end

    // Register divider
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // Run phase and restart-cover state
    phase_t phase_ff, nxt_phase;     // Analysis phase
    logic [7:0] boot_ff, nxt_boot;   // Ones shift out while pins settle
    logic   nocov_ff, nxt_nocov;     // Restarted with cover absent
    logic   any_err;                 // Some flag set
    logic   to_expired, rem_expired, fan_expired, cov_expired; // Timer outputs
    logic   fan_slow;                // Speed below minimum

    // Phase sequencing and abort
    always_comb begin
        nxt_phase = phase_ff;
        nxt_boot  = boot_ff >> 1;
        nxt_nocov = nocov_ff;
        if (boot_ff == 8'h01 && !cover_q_ff) begin
            nxt_nocov = 1'b1;
        end
        case (phase_ff)
            PH_IDLE: begin
                if (analysis_start && !any_err) nxt_phase = PH_RUN;
            end
            PH_RUN: begin
                if (any_err) begin
                    nxt_phase = PH_IDLE;
                end else if (analysis_done) begin
                    nxt_phase = timeout_en ? PH_POST : PH_IDLE;
                end
            end
            PH_POST: begin
                if (to_expired || any_err || analysis_start) nxt_phase = PH_IDLE;
            end
            default: nxt_phase = PH_IDLE;
        endcase
    end

    // Register phase state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_ff <= PH_IDLE;
            boot_ff  <= 8'hFF;
            nocov_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            boot_ff  <= nxt_boot;
            nocov_ff <= nxt_nocov;
        end
    end

    assign running = (phase_ff == PH_RUN);

    // Timeout timer: sequence not-ready or post-run wait
    ms_timer #(.W(MS_W)) u_timeout (.clk_sys(clk_sys), .rst(rst), .tick(tick),
        .active((seq_run && not_ready) || phase_ff == PH_POST),
        .limit(timeout_ticks), .expired(to_expired));

    // Remote not-ready timer from analysis start
    ms_timer #(.W(MS_W)) u_remote (.clk_sys(clk_sys), .rst(rst), .tick(tick),
        .active(running && !nrdy_q_ff),
        .limit(MS_W'(REMOTE_TO_TICKS)), .expired(rem_expired));

    // Fan slow-duration timer
    ms_timer #(.W(MS_W)) u_fan (.clk_sys(clk_sys), .rst(rst), .tick(tick),
        .active(fan_slow), .limit(MS_W'(FAN_LOW_TICKS)), .expired(fan_expired));

    // Restart without cover pump-off timer
    ms_timer #(.W(MS_W)) u_cover (.clk_sys(clk_sys), .rst(rst), .tick(tick),
        .active(nocov_ff), .limit(MS_W'(COVER_TICKS)), .expired(cov_expired));

    // Fan speed gate: count hall rises per window
    logic [15:0] win_ff, nxt_win;    // Window ticks
    logic [7:0]  revs_ff, nxt_revs;  // Revolutions this window
    logic        slow_ff, nxt_slow;  // Last window verdict

    // Count revolutions, judge at window end
    always_comb begin
        nxt_win  = win_ff;
        nxt_revs = revs_ff;
        nxt_slow = slow_ff;
        if (hall_q_ff && !hall_q_d_ff && revs_ff != 8'hFF) begin
            nxt_revs = revs_ff + 8'h01;
        end
        if (tick) begin
            if (win_ff == 16'(FAN_WIN_TICKS - 1)) begin
                nxt_win  = 16'h0000;
                nxt_slow = (revs_ff < 8'(FAN_MIN_RPS));
                nxt_revs = 8'h00;
            end else begin
                nxt_win = win_ff + 16'h0001;
            end
        end
    end

    // Register fan gate
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            win_ff  <= 16'h0000;
            revs_ff <= 8'h00;
            slow_ff <= 1'b0;
        end else begin
            win_ff  <= nxt_win;
            revs_ff <= nxt_revs;
            slow_ff <= nxt_slow;
        end
    end

    assign fan_slow = slow_ff && fan_en;

    // Solvent volume counter
    logic [VOL_W-1:0] vol_ff, nxt_vol; // Remaining volume

    // Reload on refill, count down on draw
    always_comb begin
        nxt_vol = vol_ff;
        if (solvent_reset) begin
            nxt_vol = solvent_fill;
        end else if (solvent_dec) begin
            nxt_vol = (vol_ff > VOL_W'(solvent_step)) ? vol_ff - VOL_W'(solvent_step) : '0;
        end
    end

    // Register volume
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            vol_ff <= '0;
        end else begin
            vol_ff <= nxt_vol;
        end
    end

    // Error detection and latching
    logic [NUM_ERR-1:0] err_ff, nxt_err, err_set; // Flags and raw events
    logic               cov_off_ff, nxt_cov_off;  // Pump held off by cover

    // Raw error events
    always_comb begin
        err_set                  = '0;
        err_set[E_TIMEOUT]       = to_expired;
        err_set[E_SHUTDOWN]      = !shdn_q_ff;
        err_set[E_REMOTE_TO]     = rem_expired;
        err_set[E_SYNC_LOST]     = running && ((mod_config & ~mod_present) != 16'h0000);
        err_set[E_LEAK]          = sensor_cmp.leak_detect;
        err_set[E_LEAK_OPEN]     = sensor_cmp.leak_cur_low;
        err_set[E_LEAK_SHORT]    = sensor_cmp.leak_cur_high;
        err_set[E_COMP_OPEN]     = sensor_cmp.comp_res_high;
        err_set[E_COMP_SHORT]    = sensor_cmp.comp_res_low;
        err_set[E_FAN_FAIL]      = fan_expired;
        err_set[E_OPEN_COVER]    = !cover_q_ff && !nocov_ff && (boot_ff == 8'h00);
        err_set[E_RESTART_COVER] = cov_expired;
        err_set[E_SOLVENT_ZERO]  = solvent_en && (vol_ff < solvent_limit);
        err_set[E_PRESS_HIGH]    = sensor_cmp.press_high;
    end

    // Latch flags; a set beats a clear in the same cycle
    always_comb begin
        nxt_err     = (err_ff & ~err_clear) | err_set;
        nxt_cov_off = cov_off_ff | cov_expired;
    end

    // Register flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            err_ff     <= ERR_RST;
            cov_off_ff <= 1'b0;
        end else begin
            err_ff     <= nxt_err;
            cov_off_ff <= nxt_cov_off;
        end
    end

    assign any_err = (err_ff != '0);

    // First set bit of new events, for the log
    function automatic logic [3:0] first_set(input logic [NUM_ERR-1:0] v);
        first_set = 4'h0;
        for (int i = NUM_ERR - 1; i >= 0; i--) begin
            if (v[i]) first_set = 4'(i);
        end
    endfunction

    logic [NUM_ERR-1:0] new_err;     // Flags rising this cycle
    logic               lamp_ff;     // Lamp register
    logic               abort_ff;    // Abort register
    logic               pump_ff;     // Pump enable register
    logic               fan_ff;      // Fan enable register
    log_entry_t         log_ff, nxt_log; // Log register

    // Log one entry per cycle in which a flag rises
    always_comb begin
        new_err       = err_set & ~err_ff;
        nxt_log.valid = (new_err != '0);
        nxt_log.code  = first_set(new_err);
    end

    // Register lamp, drives and log
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lamp_ff  <= 1'b0;
            abort_ff <= 1'b0;
            pump_ff  <= 1'b1;
            fan_ff   <= 1'b1;
            log_ff   <= '0;
        end else begin
            lamp_ff  <= (nxt_err != '0);
            abort_ff <= running && any_err;
            pump_ff  <= !(nxt_cov_off || err_set[E_TIMEOUT] || err_ff[E_TIMEOUT]);
            fan_ff   <= !nxt_err[E_OPEN_COVER];
            log_ff   <= nxt_log;
        end
    end

    assign err_flags      = err_ff;
    assign lamp_red       = lamp_ff;
    assign analysis_abort = abort_ff;
    assign pump_en        = pump_ff;
    assign fan_en         = fan_ff;
    assign log_entry      = log_ff;
endmodule
`default_nettype wire

// [remote_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// Instruments on the remote line and modules on the system bus
module remote_partner #(
    parameter int PROMPT = 6 // Cycles of not-ready after a start
) (
    input  wire logic        clk_sys,        // Clock
    input  wire logic        rst,            // Reset
    input  wire logic        analysis_start, // Start seen on the line
    input  wire logic        hold_nrdy,      // Keep not-ready asserted
    input  wire logic        shdn_req,       // Ask for shut-down
    input  wire logic [15:0] drop_mask,      // Modules that vanish
    input  wire logic [15:0] mod_config,     // Modules fitted
    output logic             remote_shdn_n,  // Shut-down line
    output logic             remote_nrdy_n,  // Not-ready line
    output logic [15:0]      mod_present     // Modules answering
);
    int cnt; // Not-ready cycles left

    // Not-ready after a start, freed promptly unless held
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt <= 0;
        end else if (analysis_start) begin
            cnt <= PROMPT;
        end else if (cnt != 0 && !hold_nrdy) begin
            cnt <= cnt - 1;
        end
    end

    assign remote_nrdy_n = (cnt == 0);
    assign remote_shdn_n = !shdn_req;
    assign mod_present = mod_config & ~drop_mask;
endmodule
`default_nettype wire

// [fault_sup_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// Output relations of the supervisor
module fault_sup_assertions (
    input wire logic                       clk_sys,        // Clock
    input wire logic                       rst,            // Reset
    input wire fault_sup_pkg::sensor_cmp_t sensor_cmp,     // Sensor levels
    input wire logic                       remote_shdn_n,  // Shut-down pin
    input wire logic [15:0]                mod_config,     // Modules fitted
    input wire logic [15:0]                mod_present,    // Modules seen
    input wire logic                       analysis_start, // Start pulse
    input wire logic [13:0]                err_clear,      // Clear pulses
    input wire logic [13:0]                err_flags,      // Flags
    input wire logic                       lamp_red,       // Red lamp
    input wire logic                       analysis_abort, // Abort
    input wire logic                       running,        // In run
    input wire logic                       pump_en,        // Pump on
    input wire logic                       fan_en,         // Fan on
    input wire fault_sup_pkg::log_entry_t  log_entry       // Log write
);
    import fault_sup_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Fault while running, then abort ending the run
    sequence s_run_fault; running && (|err_flags); endsequence
    sequence s_abort_end; analysis_abort ##[0:1] !running; endsequence
    sequence s_shdn_low; !remote_shdn_n [*6]; endsequence

    AST_LAMP_ON: assert property ((|err_flags) |-> ##[0:1] lamp_red)
        else $error("lamp dark with a flag set");
    AST_LAMP_OFF: assert property (!(|err_flags) ##1 !(|err_flags) |-> !lamp_red)
        else $error("lamp lit with no flag");
    AST_LOG: assert property ((err_flags & ~$past(err_flags)) != 14'h0000
        |-> ##[0:1] log_entry.valid) else $error("new flag not logged");
    AST_LOG_CODE: assert property (log_entry.valid |-> err_flags[log_entry.code])
        else $error("log code names no set flag");
    AST_ABORT: assert property (s_run_fault |-> ##[0:1] s_abort_end)
        else $error("run not aborted");
    AST_REFUSE: assert property ((|err_flags) && !running && analysis_start |=> !running)
        else $error("start taken with a flag set");
    AST_SHDN: assert property (s_shdn_low |-> err_flags[E_SHUTDOWN])
        else $error("shutdown not flagged");
    AST_SYNC: assert property (running && ((mod_config & ~mod_present) != 16'h0000)
        |=> err_flags[E_SYNC_LOST]) else $error("sync loss not flagged");
    AST_LEAK: assert property (sensor_cmp.leak_detect |=> err_flags[E_LEAK])
        else $error("leak not flagged");
    AST_PRESS: assert property (sensor_cmp.press_high |=> err_flags[E_PRESS_HIGH])
        else $error("pressure not flagged");
    AST_LATCH: assert property (($past(err_flags) & ~$past(err_clear) & ~err_flags)
        == 14'h0000) else $error("flag dropped uncleared");
    AST_PUMP_TO: assert property ($rose(err_flags[E_TIMEOUT]) |-> ##[0:1] !pump_en)
        else $error("pump on after timeout");
    AST_FAN_OFF: assert property ($rose(err_flags[E_OPEN_COVER]) |-> ##[0:1] !fan_en)
        else $error("fan on with cover open");
    AST_PUMP_CV: assert property ($rose(err_flags[E_RESTART_COVER]) |-> ##[0:1] !pump_en)
        else $error("pump on after coverless restart");
endmodule

bind fault_supervisor fault_sup_assertions u_fault_sup_assertions (.*);
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the fault supervisor
module tb_top;
    import fault_sup_pkg::*;
    localparam int TD = 4, RT = 20, FL = 10, FW = 5, CT = 10; // Short counts
    logic            clk_sys = 0, rst = 1, fan_hall = 0, cover_present = 1;
    logic            analysis_start = 0, analysis_done = 0, seq_run = 0, not_ready = 0;
    logic            timeout_en = 0, solvent_en = 0, solvent_reset = 0, solvent_dec = 0;
    logic            hold_nrdy = 0, shdn_req = 0, remote_shdn_n, remote_nrdy_n;
    logic            lamp_red, analysis_abort, running, pump_en, fan_en;
    logic [15:0]     mod_config = 16'h0003, drop_mask = 16'h0000, mod_present;
    logic [MS_W-1:0] timeout_ticks = 17'h00008;
    logic [23:0]     solvent_fill = 24'h000000, solvent_limit = 24'h000000;
    logic [7:0]      solvent_step = 8'h00;
    logic [13:0]     err_clear = 14'h0000, err_flags, exp_f = 14'h0000; // exp_f: model
    sensor_cmp_t     sensor_cmp = '0;
    log_entry_t      log_entry;
    int              num_errors = 0, tests_run = 0, cycles = 0, fan_div = 0, fan_per = 3;
    int              fmap[6] = '{13, 8, 7, 6, 5, 4}; // Flag of each sensor bit
    int              k, tt;

    fault_supervisor #(.REMOTE_TO_TICKS(RT), .FAN_LOW_TICKS(FL), .FAN_WIN_TICKS(FW),
        .COVER_TICKS(CT), .TICK_DIV(TD)) u_fault_supervisor (.*);
    remote_partner u_remote_partner (.*);

    always #5 clk_sys = ~clk_sys;

    // Fan hall pulses, stopped when fan_per is zero
    always @(negedge clk_sys) begin
        fan_div = fan_div + 1;
        if (fan_per != 0 && fan_div >= fan_per) begin
            fan_hall = ~fan_hall;
            fan_div = 0;
        end
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            num_errors = num_errors + 1;
            summarize();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkf();
        chk(32'(err_flags), 32'(exp_f));
    endtask

    // Clear flags and drop them from the model
    task automatic clr(input logic [13:0] m);
        err_clear = m;
        cyc(1);
        err_clear = 14'h0000;
        exp_f = exp_f & ~m;
        cyc(2);
    endtask

    task automatic start();
        analysis_start = 1;
        cyc(1);
        analysis_start = 0;
    endtask

    // Flag b clear after e cycles, set by cycle l
    task automatic wait_flag(input int e, input int l, input int b);
        cyc(e);
        chk(32'(err_flags[b]), 32'h0);
        cyc(l - e);
        chk(32'(err_flags[b]), 32'h1);
        exp_f[b] = 1'b1;
    endtask

    task automatic do_rst();
        rst = 1;
        cyc(5);
        rst = 0;
        exp_f = 14'h0000;
        cyc(1);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(20900));
        do_rst();
        chk(32'({lamp_red, running, pump_en, fan_en, err_flags}), 32'h0C000);
        $display("reset test done");
        tt = $urandom_range(0, 5);
        for (int n = 0; n < 6; n++) begin
            k = (n + tt) % 6;
            sensor_cmp = sensor_cmp_t'(6'(6'h01 << k));
            cyc(1);
            sensor_cmp = '0;
            cyc(2);
            exp_f[fmap[k]] = 1'b1;
            chkf();
            chk(32'(lamp_red), 32'h1);
        end
        sensor_cmp.press_high = 1'b1;
        clr(14'h3FFF);
        exp_f[E_PRESS_HIGH] = 1'b1;
        chkf();
        sensor_cmp.press_high = 1'b0;
        clr(14'h3FFF);
        chk(32'({lamp_red, err_flags}), 32'h0);
        $display("sensor test done");
        start();
        cyc(2);
        chk(32'(running), 32'h1);
        drop_mask = 16'h0002;
        cyc(4);
        drop_mask = 16'h0000;
        exp_f[E_SYNC_LOST] = 1'b1;
        chk(32'({running, err_flags}), 32'(exp_f));
        start();
        cyc(2);
        chk(32'(running), 32'h0);
        clr(14'h3FFF);
        hold_nrdy = 1;
        start();
        wait_flag(RT * TD - 4 * TD, RT * TD + 4 * TD, E_REMOTE_TO);
        chk(32'({running, err_flags}), 32'(exp_f));
        hold_nrdy = 0;
        clr(14'h3FFF);
        $display("run test done");
        shdn_req = 1;
        cyc(8);
        shdn_req = 0;
        cyc(8);
        exp_f[E_SHUTDOWN] = 1'b1;
        chkf();
        clr(14'h3FFF);
        tt = $urandom_range(4, 10);
        timeout_ticks = 17'(tt);
        seq_run = 1;
        not_ready = 1;
        wait_flag(tt * TD - 2 * TD, tt * TD + 3 * TD, E_TIMEOUT);
        seq_run = 0;
        not_ready = 0;
        clr(14'h3FFF);
        fan_per = 0;
        wait_flag(FL * TD - TD, (FL + 2 * FW + 2) * TD, E_FAN_FAIL);
        fan_per = 3;
        cyc(2 * FW * TD);
        clr(14'h3FFF);
        chkf();
        solvent_fill = 24'($urandom_range(100, 200));
        solvent_step = 8'($urandom_range(1, 20));
        solvent_limit = solvent_fill - 24'(3 * solvent_step);
        solvent_reset = 1;
        cyc(1);
        solvent_reset = 0;
        solvent_en = 1;
        for (int n = 0; n < 4; n++) begin
            if (n == 3) chkf();
            solvent_dec = 1;
            cyc(1);
            solvent_dec = 0;
            cyc(2);
        end
        exp_f[E_SOLVENT_ZERO] = 1'b1;
        chkf();
        solvent_reset = 1;
        cyc(1);
        solvent_reset = 0;
        clr(14'h3FFF);
        chkf();
        solvent_en = 0;
        $display("timer and solvent test done");
        cover_present = 0;
        cyc(8);
        chk(32'({fan_en, err_flags[E_OPEN_COVER]}), 32'h1);
        cover_present = 1;
        cyc(6);
        clr(14'h3FFF);
        cover_present = 0;
        do_rst();
        wait_flag(CT * TD - 2 * TD, CT * TD + 3 * TD, E_RESTART_COVER);
        chk(32'({pump_en, err_flags[E_OPEN_COVER]}), 32'h0);
        cover_present = 1;
        do_rst();
        timeout_en = 1;
        start();
        cyc(10);
        analysis_done = 1;
        cyc(1);
        analysis_done = 0;
        wait_flag(tt * TD - 2 * TD, tt * TD + 3 * TD, E_TIMEOUT);
        chk(32'(pump_en), 32'h0);
        $display("cover and post-run test done");
        summarize();
    end
endmodule
`default_nettype wire
